// ==== include/mitc_pkg.sv ====
// Purpose: constants and types for the instruction timing core
// Assumes: one system clock, synchronous active-high reset
// Notes:   the instruction encoding is local to this core
package mitc_pkg;

  localparam int unsigned PC_W     = 14;
  localparam int unsigned DA_W     = 8;
  localparam int unsigned IR_W     = 16;
  localparam int unsigned PHASES   = 4;
  localparam int unsigned STACK_D  = 12;
  localparam logic [7:0]  PC_LOW_ADDR = 8'h06;
  localparam logic [7:0]  TBL_ADDR = 8'h07;
  localparam logic [PC_W-1:0] RESET_PC = 14'h0000;

  // opcode in ir[15:11], operand in ir[7:0], bit index ir[10:8]
  typedef enum logic [4:0] {
    OP_NOP   = 5'h00, OP_MOVAM = 5'h01, OP_MOVMA = 5'h02,
    OP_MOVAI = 5'h03, OP_ADD   = 5'h04, OP_ADDI  = 5'h05,
    OP_SUB   = 5'h06, OP_SUBI  = 5'h07, OP_AND   = 5'h08,
    OP_OR    = 5'h09, OP_XOR   = 5'h0A, OP_COMPL = 5'h0B,
    OP_INC   = 5'h0C, OP_INC_ACC = 5'h0D, OP_DEC = 5'h0E,
    OP_DEC_ACC = 5'h0F, OP_RR  = 5'h10, OP_RL    = 5'h11,
    OP_ROR_C = 5'h12, OP_ROL_C = 5'h13, OP_SETB  = 5'h14,
    OP_CLRB  = 5'h15, OP_SZ    = 5'h16, OP_SZB   = 5'h17,
    OP_SNZB  = 5'h18, OP_JUMP  = 5'h19, OP_CALL  = 5'h1A,
    OP_SUBR_RET = 5'h1B, OP_INTR_RET = 5'h1C, OP_TABRD = 5'h1D,
    OP_HALT  = 5'h1E, OP_CLRWD = 5'h1F
  } mitc_op_t;

  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_EXTRA = 2'b01,
    ST_HALT = 2'b11
  } mitc_state_t;

  typedef struct packed {
    logic [PC_W-1:0] addr;
    logic            rd;
  } mitc_pmem_req_t;

  typedef struct packed {
    logic [7:0]      addr;
    logic [DA_W-1:0] wdata;
    logic            we;
  } mitc_dmem_req_t;

endpackage

// ==== logic/mitc_core.sv ====
// Purpose: sequencer and datapath of an 8-bit accumulator core
// Assumes: program and data memory answer combinationally
// Notes:   fetch at phase 0, execute at phase 3 of each cycle
`timescale 1ns/1ps
module mitc_core
  import mitc_pkg::*;
#(
  parameter int unsigned STACK_DEPTH = STACK_D
)(
  input  wire logic            CORE_CLK_I,
  input  wire logic            SRST_I,
  input  wire logic            WAKE_I,
  input  wire logic [IR_W-1:0] PMEM_DATA_I,
  input  wire logic [DA_W-1:0] DMEM_RDATA_I,
  output logic [PC_W-1:0]      PMEM_ADDR_O,
  output logic [7:0]           DMEM_ADDR_O,
  output logic [DA_W-1:0]      DMEM_WDATA_O,
  output logic                 DMEM_WE_O,
  output logic [DA_W-1:0]      ACC_O,
  output logic                 CARRY_O,
  output logic                 ZERO_O,
  output logic                 HALTED_O,
  output logic                 WDT_CLEAR_O,
  output logic                 INSTR_DONE_O
);

  // stack pointer is four bits wide
  if (STACK_DEPTH < 1 || STACK_DEPTH > 16)
  begin : g_bad_depth
    $error("STACK_DEPTH out of range");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    mitc_state_t                      st;
    logic [1:0]                       phase;
    logic [PC_W-1:0]                  pc;
    logic [IR_W-1:0]                  ir;
    logic [DA_W-1:0]                  acc;
    logic                             c;
    logic                             z;
    logic [STACK_DEPTH-1:0][PC_W-1:0] stk;
    logic [3:0]                       sp;
    logic [PC_W-1:0]                  tbl_ptr;
    logic [7:0]                       dm_addr;
    logic [DA_W-1:0]                  dm_wdata;
    logic                             dm_we;
    logic                             wdt_clr;
    logic                             done;
  } mitc_core_state_t;

  mitc_core_state_t s_q;
  mitc_core_state_t s_d;

  mitc_op_t        op;
  logic [2:0]      bidx;
  logic [7:0]      opnd;
  logic [8:0]      sum;
  logic [DA_W-1:0] res;
  logic            wr_mem;
  logic            wr_acc;
  logic            skip;
  logic            two_cyc;

  assign op   = mitc_op_t'(s_q.ir[15:11]);
  assign bidx = s_q.ir[10:8];
  assign opnd = s_q.ir[7:0];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d     = s_q;
    sum     = 9'h000;
    res     = s_q.acc;
    wr_mem  = 1'b0;
    wr_acc  = 1'b0;
    skip    = 1'b0;
    two_cyc = 1'b0;
    s_d.dm_we   = 1'b0;
    s_d.wdt_clr = 1'b0;
    s_d.done    = 1'b0;
    s_d.phase   = s_q.phase + 2'h1;
    s_d.dm_addr = (op == OP_TABRD) ? s_q.dm_addr : opnd;

    unique case (s_q.st)
      ST_HALT:
      begin
        s_d.phase = 2'h0;
        if (WAKE_I)
          s_d.st = ST_RUN;
      end
      ST_EXTRA:
      begin
        // second instruction cycle: no work, only elapsed time
        if (s_q.phase == 2'(PHASES - 1))
        begin
          s_d.st   = ST_RUN;
          s_d.done = 1'b1;
        end
      end
      ST_RUN:
      begin
        if (s_q.phase == 2'h0)
          s_d.ir = PMEM_DATA_I;
        if (s_q.phase == 2'(PHASES - 1))
        begin
          s_d.pc = s_q.pc + PC_W'(1);
          unique case (op)
            OP_MOVAM: begin res = DMEM_RDATA_I; wr_acc = 1'b1; end
            OP_MOVMA: begin res = s_q.acc; wr_mem = 1'b1; end
            OP_MOVAI: begin res = opnd; wr_acc = 1'b1; end
            OP_ADD, OP_ADDI:
            begin
              sum = {1'b0, s_q.acc} +
                    {1'b0, (op == OP_ADD) ? DMEM_RDATA_I : opnd};
              res = sum[7:0];
              s_d.c = sum[8];
              s_d.z = (res == 8'h00);
              wr_acc = 1'b1;
            end
            OP_SUB, OP_SUBI:
            begin
              sum = {1'b0, s_q.acc} -
                    {1'b0, (op == OP_SUB) ? DMEM_RDATA_I : opnd};
              res = sum[7:0];
              s_d.c = ~sum[8];
              s_d.z = (res == 8'h00);
              wr_acc = 1'b1;
            end
            OP_AND, OP_OR, OP_XOR:
            begin
              res = (op == OP_AND) ? (s_q.acc & DMEM_RDATA_I) :
                    (op == OP_OR)  ? (s_q.acc | DMEM_RDATA_I) :
                                     (s_q.acc ^ DMEM_RDATA_I);
              s_d.z = (res == 8'h00);
              wr_acc = 1'b1;
            end
            OP_COMPL:
            begin
              res = ~DMEM_RDATA_I;
              s_d.z = (res == 8'h00);
              wr_mem = 1'b1;
            end
            OP_INC, OP_INC_ACC, OP_DEC, OP_DEC_ACC:
            begin
              res = (op == OP_INC || op == OP_INC_ACC) ?
                    DMEM_RDATA_I + 8'h01 : DMEM_RDATA_I - 8'h01;
              s_d.z = (res == 8'h00);
              wr_mem = (op == OP_INC || op == OP_DEC);
              wr_acc = ~wr_mem;
            end
            OP_RR: begin res = {DMEM_RDATA_I[0], DMEM_RDATA_I[7:1]}; wr_mem = 1'b1; end
            OP_RL: begin res = {DMEM_RDATA_I[6:0], DMEM_RDATA_I[7]}; wr_mem = 1'b1; end
            OP_ROR_C:
            begin
              res = {s_q.c, DMEM_RDATA_I[7:1]};
              s_d.c = DMEM_RDATA_I[0];
              wr_mem = 1'b1;
            end
            OP_ROL_C:
            begin
              res = {DMEM_RDATA_I[6:0], s_q.c};
              s_d.c = DMEM_RDATA_I[7];
              wr_mem = 1'b1;
            end
            OP_SETB, OP_CLRB:
            begin
              res = DMEM_RDATA_I;
              res[bidx] = (op == OP_SETB);
              wr_mem = 1'b1;
            end
            OP_SZ:   skip = (DMEM_RDATA_I == 8'h00);
            OP_SZB:  skip = ~DMEM_RDATA_I[bidx];
            OP_SNZB: skip = DMEM_RDATA_I[bidx];
            OP_JUMP:
            begin
              s_d.pc = PC_W'(s_q.ir[10:0]);
              two_cyc = 1'b1;
            end
            OP_CALL:
            begin
              s_d.stk[s_q.sp] = s_q.pc + PC_W'(1);
              s_d.sp = (s_q.sp == 4'(STACK_DEPTH - 1)) ?
                       4'h0 : s_q.sp + 4'h1;
              s_d.pc = PC_W'(s_q.ir[10:0]);
              two_cyc = 1'b1;
            end
            OP_SUBR_RET, OP_INTR_RET:
            begin
              s_d.sp = (s_q.sp == 4'h0) ?
                       4'(STACK_DEPTH - 1) : s_q.sp - 4'h1;
              s_d.pc = s_q.stk[s_d.sp];
              two_cyc = 1'b1;
            end
            OP_TABRD:
            begin
              // table pointer set by an earlier write to TBL_ADDR
              res = PMEM_DATA_I[7:0];
              wr_acc = 1'b1;
              two_cyc = 1'b1;
            end
            OP_HALT:  s_d.st = ST_HALT;
            OP_CLRWD: s_d.wdt_clr = 1'b1;
            OP_NOP:   ;
          endcase

          if (wr_acc)
            s_d.acc = res;
          if (wr_mem)
          begin
            s_d.dm_wdata = res;
            s_d.dm_we    = 1'b1;
            if (opnd == PC_LOW_ADDR)
            begin
              s_d.pc  = {s_q.pc[PC_W-1:8], res};
              two_cyc = 1'b1;
            end
            if (opnd == TBL_ADDR)
              s_d.tbl_ptr = {s_q.pc[PC_W-1:8], res};
          end
          if (skip)
          begin
            s_d.pc  = s_q.pc + PC_W'(2);
            two_cyc = 1'b1;
          end
          if (two_cyc && s_d.st != ST_HALT)
            s_d.st = ST_EXTRA;
          else
            s_d.done = 1'b1;
        end
      end
      default: s_d.st = ST_RUN;
    endcase
  end

  // ----------------------------------------------------------------
  // register
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I)
    begin
      s_q    <= '0;
      s_q.st <= ST_RUN;
      s_q.pc <= RESET_PC;
    end
    else
      s_q <= s_d;
  end

  assign PMEM_ADDR_O  = (op == OP_TABRD && s_q.phase != 2'h0) ?
                        s_q.tbl_ptr : s_q.pc;
  assign DMEM_ADDR_O  = s_q.dm_addr;
  assign DMEM_WDATA_O = s_q.dm_wdata;
  assign DMEM_WE_O    = s_q.dm_we;
  assign ACC_O        = s_q.acc;
  assign CARRY_O      = s_q.c;
  assign ZERO_O       = s_q.z;
  assign HALTED_O     = (s_q.st == ST_HALT);
  assign WDT_CLEAR_O  = s_q.wdt_clr;
  assign INSTR_DONE_O = s_q.done;

endmodule // mitc_core

// ==== bench/mitc_core_monitor.sv ====
// Purpose: pacing and pulse checks on the core outputs
// Assumes: one clock, synchronous active-high reset
// Notes:   bound into every mitc_core instance
`timescale 1ns/1ps
module mitc_core_checker
  import mitc_pkg::*;
(
  input wire logic            CORE_CLK_I,
  input wire logic            SRST_I,
  input wire logic            WAKE_I,
  input wire logic [DA_W-1:0] ACC_O,
  input wire logic            CARRY_O,
  input wire logic            HALTED_O,
  input wire logic            DMEM_WE_O,
  input wire logic            WDT_CLEAR_O,
  input wire logic            INSTR_DONE_O
);
  default clocking mitc_cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (SRST_I);
  // ----------
  // properties
  // ----------
  done_min_gap_a: assert property (INSTR_DONE_O |=> !INSTR_DONE_O [*3])
    else $error("instruction shorter than four clocks");
  done_max_gap_a: assert property (
    INSTR_DONE_O |-> ##[4:8] (INSTR_DONE_O || HALTED_O))
    else $error("instruction longer than two cycles");
  state_hold_a: assert property (
    !$stable(ACC_O) || !$stable(CARRY_O) |-> ##[0:4] INSTR_DONE_O)
    else $error("accumulator changed between instructions");
  write_pulse_a: assert property (DMEM_WE_O |=> !DMEM_WE_O)
    else $error("write strobe longer than one clock");
  write_in_instr_a: assert property (DMEM_WE_O |-> ##[0:4] INSTR_DONE_O)
    else $error("write outside an instruction");
  wdt_pulse_a: assert property (WDT_CLEAR_O |=> !WDT_CLEAR_O)
    else $error("watchdog clear longer than one clock");
  halt_quiet_a: assert property (
    HALTED_O && $past(HALTED_O) |-> !INSTR_DONE_O && !DMEM_WE_O)
    else $error("activity while halted");
  wake_exit_a: assert property (HALTED_O && WAKE_I |-> ##[1:8] !HALTED_O)
    else $error("wake did not leave halt");
endmodule // mitc_core_checker

bind mitc_core mitc_core_checker mitc_core_checker_inst (
  .CORE_CLK_I, .SRST_I, .WAKE_I, .ACC_O, .CARRY_O, .HALTED_O, .DMEM_WE_O,
  .WDT_CLEAR_O, .INSTR_DONE_O);

// ==== bench/mitc_mem_model.sv ====
// Purpose: program and data memory facing the core
// Assumes: reads answer within the same clock
// Notes:   256 words each; upper address bits alias
`timescale 1ns/1ps
module mitc_mem_model
  import mitc_pkg::*;
(
  input  wire logic            clk_i,
  input  wire logic [PC_W-1:0] pmem_addr_i,
  output logic [IR_W-1:0]      pmem_data_o,
  input  wire logic [7:0]      dmem_addr_i,
  input  wire logic [DA_W-1:0] dmem_wdata_i,
  input  wire logic            dmem_we_i,
  output logic [DA_W-1:0]      dmem_rdata_o
);
  logic [IR_W-1:0] pmem [0:255];
  logic [DA_W-1:0] dmem [0:255];
  // table words share the code array
  assign pmem_data_o  = pmem[pmem_addr_i[7:0]];
  assign dmem_rdata_o = dmem[dmem_addr_i];
  always @(posedge clk_i)
  begin
    if (dmem_we_i === 1'b1) dmem[dmem_addr_i] <= dmem_wdata_i;
  end
endmodule // mitc_mem_model

// ==== bench/mitc_core_tb.sv ====
// Purpose: directed programs run through the core
// Assumes: memory model answers combinationally
// Notes:   spare words hold halt, so a stray fetch stalls the run
`timescale 1ns/1ps
module mitc_core_tb import mitc_pkg::*;;
  typedef struct {logic [7:0] a; logic [1:0] f; int n;} mitc_exp_t;
  logic            clk, srst, wake, wdt_seen, dwe, carry, zero, halted;
  logic            wdt, done;
  logic [IR_W-1:0] pdata;
  logic [PC_W-1:0] paddr;
  logic [7:0]      drdata, dwdata, acc, daddr, at;
  int              err_count, cmp_count;
  mitc_exp_t       exp_q[$];
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  mitc_core mitc_core_inst (.CORE_CLK_I(clk), .SRST_I(srst), .WAKE_I(wake),
    .PMEM_DATA_I(pdata), .DMEM_RDATA_I(drdata), .PMEM_ADDR_O(paddr),
    .DMEM_ADDR_O(daddr), .DMEM_WDATA_O(dwdata), .DMEM_WE_O(dwe),
    .ACC_O(acc), .CARRY_O(carry), .ZERO_O(zero), .HALTED_O(halted),
    .WDT_CLEAR_O(wdt), .INSTR_DONE_O(done));
  mitc_mem_model mem_inst (.clk_i(clk), .pmem_addr_i(paddr),
    .pmem_data_o(pdata), .dmem_addr_i(daddr), .dmem_wdata_i(dwdata),
    .dmem_we_i(dwe), .dmem_rdata_o(drdata));
  always @(posedge clk)
  begin
    if (wdt === 1'b1) wdt_seen <= 1'b1;
  end
  // ---------------
  // shared helpers
  // ---------------
  task automatic chk(string what, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic op(mitc_op_t o, logic [2:0] b, logic [7:0] m,
                    logic [7:0] a, logic [1:0] f, int n);
    mem_inst.pmem[at] = {o, b, m};
    at = at + 8'h01;
    exp_q.push_back('{a, f, n});
  endtask
  task automatic wipe();
    at = 8'h00;
    for (int k = 0; k < 256; k++)
    begin
      mem_inst.pmem[k] = {OP_HALT, 11'h000};
      mem_inst.dmem[k] = 8'h00;
    end
  endtask
  // flags expected as {carry, zero}; n of 0 skips the gap check
  task automatic step(mitc_exp_t x);
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (done !== 1'b1 && n < 40);
    chk("done", 8'h01, 8'(done));
    if (x.n != 0) chk("cycles", 8'(x.n), 8'(n));
    chk("acc", x.a, acc);
    chk("flags", 8'(x.f), 8'({carry, zero}));
  endtask
  task automatic go(string name);
    wdt_seen = 1'b0;
    @(posedge clk);
    srst <= 1'b1;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    foreach (exp_q[k]) step(exp_q[k]);
    exp_q.delete();
    $display("test %s done", name);
  endtask
  // ---------
  // scenarios
  // ---------
  task automatic test_alu();
    wipe();
    mem_inst.dmem[16] = 8'hA5;
    op(OP_MOVAI, 3'h0, 8'hFF, 8'hFF, 2'h0, 0);
    op(OP_ADDI, 3'h0, 8'h01, 8'h00, 2'h3, 4);
    op(OP_SUBI, 3'h0, 8'h01, 8'hFF, 2'h0, 4);
    op(OP_MOVAI, 3'h0, 8'h5A, 8'h5A, 2'h0, 4);
    op(OP_AND, 3'h0, 8'h10, 8'h00, 2'h1, 4);
    op(OP_OR, 3'h0, 8'h10, 8'hA5, 2'h0, 4);
    op(OP_XOR, 3'h0, 8'h10, 8'h00, 2'h1, 4);
    op(OP_COMPL, 3'h0, 8'h10, 8'h00, 2'h0, 4);
    op(OP_INC_ACC, 3'h0, 8'h10, 8'h5B, 2'h0, 4);
    op(OP_DEC, 3'h0, 8'h10, 8'h5B, 2'h0, 4);
    op(OP_ROR_C, 3'h0, 8'h10, 8'h5B, 2'h2, 4);
    op(OP_MOVAM, 3'h0, 8'h10, 8'h2C, 2'h2, 4);
    op(OP_ROL_C, 3'h0, 8'h10, 8'h2C, 2'h0, 4);
    op(OP_SETB, 3'h7, 8'h10, 8'h2C, 2'h0, 4);
    op(OP_CLRB, 3'h0, 8'h10, 8'h2C, 2'h0, 4);
    op(OP_MOVAM, 3'h0, 8'h10, 8'hD8, 2'h0, 4);
    go("alu");
  endtask
  task automatic test_flow();
    wipe();
    mem_inst.pmem[64] = 16'h7EC3;
    mem_inst.pmem[27] = {OP_MOVAI, 3'h0, 8'h77};
    mem_inst.dmem[33] = 8'h01;
    op(OP_NOP, 3'h0, 8'h00, 8'h00, 2'h0, 0);
    op(OP_JUMP, 3'h0, 8'h04, 8'h00, 2'h0, 8);
    at = 8'h04;
    op(OP_CALL, 3'h0, 8'h08, 8'h00, 2'h0, 8);
    at = 8'h08;
    op(OP_MOVAI, 3'h0, 8'h11, 8'h11, 2'h0, 4);
    op(OP_SUBR_RET, 3'h0, 8'h00, 8'h11, 2'h0, 8);
    at = 8'h05;
    op(OP_MOVMA, 3'h0, 8'h06, 8'h11, 2'h0, 8);
    at = 8'h11;
    op(OP_MOVAI, 3'h0, 8'h22, 8'h22, 2'h0, 4);
    op(OP_SZ, 3'h0, 8'h20, 8'h22, 2'h0, 8);
    at = 8'h14;
    op(OP_SZB, 3'h0, 8'h21, 8'h22, 2'h0, 4);
    op(OP_MOVAI, 3'h0, 8'h40, 8'h40, 2'h0, 4);
    op(OP_MOVMA, 3'h0, 8'h07, 8'h40, 2'h0, 4);
    op(OP_TABRD, 3'h0, 8'h22, 8'hC3, 2'h0, 8);
    op(OP_MOVMA, 3'h0, 8'h22, 8'hC3, 2'h0, 4);
    op(OP_CLRWD, 3'h0, 8'h00, 8'hC3, 2'h0, 4);
    go("flow");
  endtask
  task automatic test_halt();
    int n;
    n = 0;
    repeat (12) @(negedge clk);
    chk("halted", 8'h01, 8'(halted));
    chk("wdt_clear", 8'h01, 8'(wdt_seen));
    repeat (16)
    begin
      @(negedge clk);
      if (done === 1'b1) n++;
    end
    chk("halt_done", 8'h00, 8'(n));
    @(posedge clk);
    wake <= 1'b1;
    step('{8'h77, 2'h0, 0});
    @(posedge clk);
    wake <= 1'b0;
    $display("test halt done");
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (3000) @(posedge clk);
    err_count++;
    $display("[ERR] run_time expected finish seen timeout");
    stop_test();
  end
  initial
  begin
    srst = 1'b1;
    wake = 1'b0;
    err_count = 0;
    cmp_count = 0;
    test_alu();
    test_flow();
    test_halt();
    stop_test();
  end
endmodule // mitc_core_tb
